// >>> shared/accu_x_consts.svh
`ifndef ACCU_X_CONSTS_SVH
`define ACCU_X_CONSTS_SVH
`define OP_ARITH        8'h21
`define OP_AXIS_PARAM   8'h22
`define OP_GLOBAL_PARAM 8'h23
`define OP_CLEAR_FLAGS  8'h24
`define OP_INT_UNMASK   8'h19
`define ST_OK           8'h64
`define ST_BAD_SUM      8'h01
`define ST_BAD_CMD      8'h02
`define ST_BAD_TYPE     8'h03
`define ST_BAD_MOTOR    8'h04
`define INT_GLOBAL      8'hFF
`define MODULE_ADDR     8'h01
`define REPLY_ADDR      8'h02
`define FRAME_LAST      4'h8
`define DIV_STEPS       6'h20
`define FLAG_TIMEOUT    3'h1
`define FLAG_ALARM      3'h2
`define FLAG_DEVIATION  3'h3
`define FLAG_POSITION   3'h4
`define FLAG_SHUTDOWN   3'h5
`define TY_ADD  8'h00
`define TY_SUB  8'h01
`define TY_MUL  8'h02
`define TY_DIV  8'h03
`define TY_MOD  8'h04
`define TY_AND  8'h05
`define TY_OR   8'h06
`define TY_XOR  8'h07
`define TY_NOT  8'h08
`define TY_LOAD 8'h09
`define TY_SWAP 8'h0A
`endif

// >>> shared/accu_x_pkg.sv
package accu_x_pkg;
  // One decoded command frame
  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  ctype;
    logic [7:0]  bank;
    logic [31:0] value;
  } command_s;
  // One reply frame
  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  opcode;
    logic [31:0] value;
  } reply_s;
  // Parameter write toward the parameter tables
  typedef struct packed {
    logic        axis;
    logic [7:0]  number;
    logic [7:0]  bank;
    logic [31:0] data;
  } param_write_s;
  // Error flag vector, index = clear type
  typedef logic [5:1] error_flags_t;
endpackage

// >>> rtl/frame_receiver.sv
`timescale 1ns/1ps
`include "accu_x_consts.svh"
// Gathers nine-byte frames and checks the checksum
module frame_receiver (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  byte_valid_i,
  input  wire logic [7:0]            byte_i,
  output logic                       frame_valid_o,
  output logic                       frame_sum_ok_o,
  output accu_x_pkg::command_s       frame_o
);
  import accu_x_pkg::*;
  // Whole state in one struct
  typedef struct packed {
    logic [3:0]  index;
    logic [7:0]  sum;
    logic [7:0]  addr;
    command_s    cmd;
    logic        done;
    logic        ok;
  } rx_state_s;
  rx_state_s state, next_state;

  // Byte position decode
  always_comb begin
    next_state      = state;
    next_state.done = 1'b0;
    if (byte_valid_i) begin
      case (state.index)
        4'h0: next_state.addr = byte_i;
        4'h1: next_state.cmd.opcode = byte_i;
        4'h2: next_state.cmd.ctype = byte_i;
        4'h3: next_state.cmd.bank = byte_i;
        // Value bytes, most significant first
        4'h4, 4'h5, 4'h6, 4'h7: next_state.cmd.value = {state.cmd.value[23:0], byte_i};
        default: ;
      endcase
      if (state.index == `FRAME_LAST) begin
        // Checksum is the sum of the first eight bytes
        next_state.done  = (state.addr == `MODULE_ADDR);
        next_state.ok    = (state.sum == byte_i);
        next_state.index = 4'h0;
        next_state.sum   = 8'h00;
      end else begin
        next_state.index = state.index + 4'h1;
        next_state.sum   = state.sum + byte_i;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign frame_valid_o  = state.done;
  assign frame_sum_ok_o = state.ok;
  assign frame_o        = state.cmd;
endmodule

// >>> rtl/serial_divider.sv
`timescale 1ns/1ps
`include "accu_x_consts.svh"
// Signed 32-bit restoring divider, one quotient bit per cycle
module serial_divider (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic [31:0] dividend_i,
  input  wire logic [31:0] divisor_i,
  output logic             done_o,
  output logic [31:0]      quotient_o,
  output logic [31:0]      remainder_o
);
  import accu_x_pkg::*;
  // Whole state in one struct
  typedef struct packed {
    logic        busy;
    logic        done;
    logic [5:0]  count;
    logic [31:0] quo;
    logic [32:0] rem;
    logic [31:0] dsr;
    logic        neg_q;
    logic        neg_r;
  } div_state_s;
  div_state_s state, next_state;
  logic [32:0] trial;

  // Shift-subtract step; truncating division like C
  always_comb begin
    next_state      = state;
    next_state.done = 1'b0;
    trial           = {state.rem[31:0], state.quo[31]} - {1'b0, state.dsr};
    if (start_i && !state.busy) begin
      next_state.busy  = 1'b1;
      next_state.count = `DIV_STEPS;
      next_state.quo   = dividend_i[31] ? 32'(-dividend_i) : dividend_i;
      next_state.dsr   = divisor_i[31] ? 32'(-divisor_i) : divisor_i;
      next_state.rem   = 33'h0_0000_0000;
      next_state.neg_q = dividend_i[31] ^ divisor_i[31];
      next_state.neg_r = dividend_i[31];
    end else if (state.busy) begin
      if (trial[32]) begin
        next_state.rem = {state.rem[31:0], state.quo[31]};
        next_state.quo = {state.quo[30:0], 1'b0};
      end else begin
        next_state.rem = trial;
        next_state.quo = {state.quo[30:0], 1'b1};
      end
      next_state.count = state.count - 6'h01;
      if (state.count == 6'h01) begin
        next_state.busy = 1'b0;
        next_state.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign done_o      = state.done;
  assign quotient_o  = state.neg_q ? 32'(-state.quo) : state.quo;
  assign remainder_o = state.neg_r ? 32'(-state.rem[31:0]) : state.rem[31:0];
endmodule

// >>> rtl/accu_x_command_executor.sv
`timescale 1ns/1ps
`include "accu_x_consts.svh"
// Executes arithmetic, parameter transfer, flag clear and interrupt enable
// commands against the accumulator and the second operand register.
module accu_x_command_executor (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Command link bytes
  input  wire logic                       rx_valid_i,
  input  wire logic [7:0]                 rx_byte_i,
  // Standalone program command
  input  wire logic                       prog_valid_i,
  input  wire accu_x_pkg::command_s       prog_cmd_i,
  // Accumulator load from other commands
  input  wire logic                       accu_load_i,
  input  wire logic [31:0]                accu_load_value_i,
  // Error flag set events
  input  wire accu_x_pkg::error_flags_t   flag_set_i,
  // Wishbone classic slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [3:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic [31:0]                     wb_dat_o,
  output logic                            wb_ack_o,
  // Results
  output logic                            busy_o,
  output logic                            reply_valid_o,
  output accu_x_pkg::reply_s              reply_o,
  output logic                            param_valid_o,
  output accu_x_pkg::param_write_s        param_o,
  output logic [31:0]                     accu_o,
  output logic [31:0]                     x_o,
  output accu_x_pkg::error_flags_t        flags_o,
  output logic [7:0]                      int_source_enable_o,
  output logic                            int_global_enable_o,
  output logic                            irq_o
);
  import accu_x_pkg::*;

  // Register word indices
  localparam logic [3:0] REG_ACCU   = 4'h0;
  localparam logic [3:0] REG_X      = 4'h1;
  localparam logic [3:0] REG_FLAGS  = 4'h2;
  localparam logic [3:0] REG_INTEN  = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_MASK   = 4'h5;

  // Event bits of the sticky status
  localparam int EV_DONE  = 0;
  localparam int EV_ERROR = 1;
  localparam int EV_FLAG  = 2;

  // Executor sequencing
  typedef enum logic [1:0] {
    IDLE   = 2'b00,
    DIVIDE = 2'b01,
    REPLY  = 2'b10
  } exec_e;

  // All module state in one struct
  // Outputs read it directly
  typedef struct packed {
    exec_e         phase;
    logic          direct;
    command_s      cmd;
    logic signed [31:0] accu;
    logic signed [31:0] x;
    error_flags_t  flags;
    logic [7:0]    int_en;
    logic          int_global;
    logic [2:0]    status;
    logic [2:0]    mask;
    logic          reply_valid;
    reply_s        reply;
    logic          param_valid;
    param_write_s  param;
    logic          ack;
    logic [31:0]   rdata;
    logic          irq;
  } top_state_s;
  top_state_s state, next_state;

  // Receiver outputs
  logic          frame_valid;
  logic          frame_ok;
  command_s      frame_cmd;
  // Divider handshake
  logic          div_start;
  logic          div_done;
  logic [31:0]   div_quo;
  logic [31:0]   div_rem;
  // Execution scratch
  logic [63:0]   product;
  logic [7:0]    stat;
  logic [2:0]    events;
  // Bus request decode
  logic          wb_req;
  logic          wb_wr;

  // Frame assembly and checksum
  frame_receiver u_rx (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .byte_valid_i   (rx_valid_i),
    .byte_i         (rx_byte_i),
    .frame_valid_o  (frame_valid),
    .frame_sum_ok_o (frame_ok),
    .frame_o        (frame_cmd)
  );

  // Division shares one sequential unit
  serial_divider u_div (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .start_i     (div_start),
    .dividend_i  (state.accu),
    .divisor_i   (state.x),
    .done_o      (div_done),
    .quotient_o  (div_quo),
    .remainder_o (div_rem)
  );

  // Signed product, low word kept
  assign product = 64'(state.accu * state.x);
  assign wb_req  = wb_cyc_i && wb_stb_i && !state.ack;
  assign wb_wr   = wb_req && wb_we_i;

  // Command execution, flags, register bus, interrupt
  always_comb begin
    next_state             = state;
    next_state.reply_valid = 1'b0;
    next_state.param_valid = 1'b0;
    next_state.ack         = 1'b0;
    div_start              = 1'b0;
    stat                   = `ST_OK;
    events                 = 3'b000;
    case (state.phase)
      IDLE: begin
        // Link frames take priority over the program
        if (frame_valid) begin
          next_state.cmd    = frame_cmd;
          next_state.direct = 1'b1;
          next_state.phase  = frame_ok ? DIVIDE : REPLY;
          next_state.reply  = '{status: `ST_BAD_SUM, opcode: frame_cmd.opcode, value: 32'h0000_0000};
        end else if (prog_valid_i) begin
          next_state.cmd    = prog_cmd_i;
          next_state.direct = 1'b0;
          next_state.phase  = DIVIDE;
        end else if (accu_load_i) begin
          next_state.accu = accu_load_value_i;
        end
      end
      DIVIDE: begin
        // Execute; divisions wait on the divider
        next_state.phase = REPLY;
        case (state.cmd.opcode)
          `OP_ARITH: begin
            // Operands accumulator and X register; NOT and LOAD write X, SWAP writes both, the rest write the accumulator
            case (state.cmd.ctype)
              `TY_ADD: next_state.accu = state.accu + state.x;
              `TY_SUB: next_state.accu = state.accu - state.x;
              `TY_MUL: next_state.accu = product[31:0];
              `TY_DIV, `TY_MOD: begin
                // Zero divisor refused rather than hanging
                if (state.x == 32'sh0000_0000) begin
                  stat = `ST_BAD_TYPE;
                end else begin
                  div_start        = !div_done;
                  next_state.phase = div_done ? REPLY : DIVIDE;
                  if (div_done) begin
                    next_state.accu = (state.cmd.ctype == `TY_DIV) ? div_quo : div_rem;
                  end
                end
              end
              `TY_AND: next_state.accu = state.accu & state.x;
              `TY_OR:  next_state.accu = state.accu | state.x;
              `TY_XOR: next_state.accu = state.accu ^ state.x;
              `TY_NOT: next_state.x = ~state.x;
              `TY_LOAD: next_state.x = state.accu;
              `TY_SWAP: begin
                next_state.accu = state.x;
                next_state.x    = state.accu;
              end
              default: stat = `ST_BAD_TYPE;
            endcase
          end
          `OP_AXIS_PARAM: begin
            // Single axis: motor must be zero
            if (state.cmd.bank != 8'h00) begin
              stat = `ST_BAD_MOTOR;
            end else begin
              next_state.param_valid = 1'b1;
              next_state.param = '{axis: 1'b1, number: state.cmd.ctype, bank: 8'h00, data: state.accu};
            end
          end
          // Bank passes through
          `OP_GLOBAL_PARAM: begin
            next_state.param_valid = 1'b1;
            next_state.param = '{axis: 1'b0, number: state.cmd.ctype, bank: state.cmd.bank,
                                 data: state.accu};
          end
          // Set beats clear below
          `OP_CLEAR_FLAGS: begin
            if (state.cmd.ctype == 8'h00) begin
              next_state.flags = '0;
            end else if (state.cmd.ctype <= {5'h00, `FLAG_SHUTDOWN}) begin
              next_state.flags[state.cmd.ctype[2:0]] = 1'b0;
            end else begin
              stat = `ST_BAD_TYPE;
            end
          end
          // 255 is the global switch
          `OP_INT_UNMASK: begin
            if (state.cmd.ctype == `INT_GLOBAL) begin
              next_state.int_global = 1'b1;
            end else if (state.cmd.ctype < 8'h08) begin
              next_state.int_en[state.cmd.ctype[2:0]] = 1'b1;
            end else begin
              stat = `ST_BAD_TYPE;
            end
          end
          // Unknown opcodes refused
          default: stat = `ST_BAD_CMD;
        endcase
        next_state.reply = '{status: stat, opcode: state.cmd.opcode, value: 32'h0000_0000};
      end
      // Closing cycle of a command
      REPLY: begin
        // Reply only for link commands, value carries nothing
        next_state.reply_valid = state.direct;
        next_state.phase       = IDLE;
        events[EV_DONE]        = 1'b1;
        events[EV_ERROR]       = (state.reply.status != `ST_OK);
      end
      // Stray phase code recovers
      default: next_state.phase = IDLE;
    endcase
    // Flag set events win over a clear in the same cycle
    next_state.flags = next_state.flags | flag_set_i;
    events[EV_FLAG]  = |flag_set_i;
    // Register bus writes
    if (wb_wr && wb_sel_i[0]) begin
      case (wb_adr_i)
        REG_ACCU:  next_state.accu = wb_dat_i;
        REG_X:     next_state.x = wb_dat_i;
        REG_INTEN: begin
          next_state.int_en     = wb_dat_i[7:0];
          next_state.int_global = wb_dat_i[8];
        end
        REG_STATUS: next_state.status = state.status & ~wb_dat_i[2:0];
        REG_MASK:  next_state.mask = wb_dat_i[2:0];
        default: ;
      endcase
    end
    // Sticky events override a clear
    next_state.status = next_state.status | events;
    // Register bus reads, unmapped reads as zero
    if (wb_req) begin
      next_state.ack = 1'b1;
      case (wb_adr_i)
        REG_ACCU:   next_state.rdata = state.accu;
        REG_X:      next_state.rdata = state.x;
        REG_FLAGS:  next_state.rdata = {26'h000_0000, state.flags, 1'b0};
        REG_INTEN:  next_state.rdata = {23'h00_0000, state.int_global, state.int_en};
        REG_STATUS: next_state.rdata = {29'h0000_0000, state.status};
        REG_MASK:   next_state.rdata = {29'h0000_0000, state.mask};
        default:    next_state.rdata = 32'h0000_0000;
      endcase
    end
    next_state.irq = |(next_state.status & next_state.mask);
  end

  // State register
  // Reset clears all fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // All outputs are flops, except busy_o decoded from the phase
  assign wb_ack_o            = state.ack;
  assign wb_dat_o            = state.rdata;
  assign busy_o              = (state.phase != IDLE);
  assign reply_valid_o       = state.reply_valid;
  assign reply_o             = state.reply;
  assign param_valid_o       = state.param_valid;
  assign param_o             = state.param;
  assign accu_o              = state.accu;
  assign x_o                 = state.x;
  assign flags_o             = state.flags;
  assign int_source_enable_o = state.int_en;
  assign int_global_enable_o = state.int_global;
  assign irq_o               = state.irq;
endmodule

// >>> sim/accu_x_host_model.sv
`timescale 1ns/1ps
// Host on the command link: sends nine-byte frames, one byte per clock
module accu_x_host_model (
  input  wire logic       clk_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_byte_o
);
  logic [7:0] frame_b [9];  // Frame in flight

  // Idle link at time zero
  initial begin
    rx_valid_o = 1'b0;
    rx_byte_o  = 8'hA5;
  end

  // Address, opcode, type, bank, value MSB first, then sum; corrupt spoils the sum
  task automatic send(input logic [7:0] op, ty, bank, input logic [31:0] val, input logic corrupt);
    logic [7:0] sum;
    frame_b = '{8'h01, op, ty, bank, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
    sum = 8'h00;
    for (int i = 0; i < 8; i++) sum += frame_b[i];
    frame_b[8] = corrupt ? ~sum : sum;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_byte_o  <= frame_b[i];
    end
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    // Released line shows no stale byte
    rx_byte_o  <= ~frame_b[8];
  endtask
endmodule

// >>> sim/accu_x_command_executor_props.sv
`timescale 1ns/1ps
// Port-level checks of the executor; one clock domain
module accu_x_command_executor_props (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     accu_load_i,
  input  wire logic                     wb_ack_o,
  input  wire logic                     busy_o,
  input  wire logic                     reply_valid_o,
  input  wire accu_x_pkg::reply_s       reply_o,
  input  wire logic                     param_valid_o,
  input  wire accu_x_pkg::param_write_s param_o,
  input  wire logic [31:0]              accu_o,
  input  wire logic [31:0]              x_o,
  input  wire accu_x_pkg::error_flags_t flags_o,
  input  wire logic                     int_global_enable_o
);
  import accu_x_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Bus answers exactly one cycle after a fresh request
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack not one cycle after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  // Reply is a single pulse at the end of busy
  chk_reply_single: assert property (reply_valid_o |=> !reply_valid_o)
    else $error("reply strobe longer than one cycle");
  chk_reply_after_busy: assert property (reply_valid_o |-> $past(busy_o) && !busy_o)
    else $error("reply not at end of execution");
  chk_ok_value_zero: assert property (reply_valid_o && reply_o.status == 8'h64 |-> reply_o.value == 32'h0)
    else $error("success reply carries a value");
  // Divide is the longest operation, well inside this bound
  chk_busy_bounded: assert property ($rose(busy_o) |-> ##[1:60] !busy_o)
    else $error("command execution does not finish");
  chk_param_data: assert property (param_valid_o |-> param_o.data == accu_o)
    else $error("parameter write data differs from accumulator");
  // Registers move only through commands, bus writes or loads
  chk_accu_cause: assert property ($changed(accu_o) |-> $past(busy_o) || wb_ack_o || $past(wb_ack_o) || $past(accu_load_i))
    else $error("accumulator changed without a cause");
  chk_x_cause: assert property ($changed(x_o) |-> $past(busy_o) || wb_ack_o || $past(wb_ack_o))
    else $error("second operand changed without a cause");
  chk_flag_clear: assert property (|($past(flags_o) & ~flags_o) |-> $past(busy_o))
    else $error("error flag cleared outside a command");
  chk_global_cause: assert property ($rose(int_global_enable_o) |-> $past(busy_o))
    else $error("global interrupt enable set outside a command");

  // Main scenarios reached
  cov_arith_reply: cover property (reply_valid_o && reply_o.opcode == 8'h21);
  cov_axis_write: cover property (param_valid_o && param_o.axis);
  cov_global_on: cover property ($rose(int_global_enable_o));
endmodule

bind accu_x_command_executor accu_x_command_executor_props props_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .accu_load_i, .wb_ack_o, .busy_o, .reply_valid_o, .reply_o, .param_valid_o, .param_o, .accu_o, .x_o,
  .flags_o, .int_global_enable_o);

// >>> sim/accu_x_command_executor_tb.sv
`timescale 1ns/1ps
`include "accu_x_consts.svh"
// Self-checking bench: arithmetic table, then hand-written cases
module accu_x_command_executor_tb;
  import accu_x_pkg::*;
  typedef struct packed {logic [7:0] ty; logic [31:0] a; logic [31:0] x;} row_s;
  logic         clk_i = 1'b0;          // 200 MHz clock
  logic         rst_i = 1'b1;          // Synchronous reset
  logic         rx_valid_i;            // From host model
  logic [7:0]   rx_byte_i;             // From host model
  logic         prog_valid_i = 1'b0;   // Standalone strobe
  command_s     prog_cmd_i = '0;       // Standalone command
  logic         accu_load_i = 1'b0;    // Accumulator load strobe
  logic [31:0]  accu_load_value_i = '0;
  error_flags_t flag_set_i = '0;       // Flag events
  logic         wb_cyc_i = 1'b0;
  logic         wb_stb_i = 1'b0;
  logic         wb_we_i = 1'b0;
  logic [3:0]   wb_adr_i = '0;
  logic [3:0]   wb_sel_i = '0;
  logic [31:0]  wb_dat_i = '0;
  logic [31:0]  wb_dat_o, accu_o, x_o, rdat;
  logic         wb_ack_o, busy_o, reply_valid_o, param_valid_o, int_global_enable_o, irq_o;
  reply_s       reply_o;
  param_write_s param_o;
  error_flags_t flags_o;
  logic [7:0]   int_source_enable_o;
  int           err_total = 0;         // Mismatches
  int           n_tests = 0;           // Comparisons
  // Accumulator -17, second operand 5 before each row
  row_s rows [11] = '{'{8'h00, 32'hFFFFFFF4, 32'h5}, '{8'h01, 32'hFFFFFFEA, 32'h5}, '{8'h02, 32'hFFFFFFAB, 32'h5},
    '{8'h03, 32'hFFFFFFFD, 32'h5}, '{8'h04, 32'hFFFFFFFE, 32'h5}, '{8'h05, 32'h5, 32'h5},
    '{8'h06, 32'hFFFFFFEF, 32'h5}, '{8'h07, 32'hFFFFFFEA, 32'h5}, '{8'h08, 32'hFFFFFFEF, 32'hFFFFFFFA},
    '{8'h09, 32'hFFFFFFEF, 32'hFFFFFFEF}, '{8'h0A, 32'h5, 32'hFFFFFFEF}};

  accu_x_command_executor accu_x_command_executor_i (.clk_i, .rst_i, .rx_valid_i, .rx_byte_i, .prog_valid_i,
    .prog_cmd_i, .accu_load_i, .accu_load_value_i, .flag_set_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .busy_o, .reply_valid_o, .reply_o, .param_valid_o, .param_o,
    .accu_o, .x_o, .flags_o, .int_source_enable_o, .int_global_enable_o, .irq_o);
  accu_x_host_model accu_x_host_model_i (.clk_i, .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i));

  // Free-running clock
  always #2.5 clk_i = ~clk_i;

  // One comparison, four-state exact
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rdat = wb_dat_o;
    check("bus answer", 64'(n < 50), 64'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  // Send a frame and wait, bounded, for its reply
  task automatic cmd(input logic [7:0] op, ty, bank, input logic bad, input logic [7:0] st);
    int n;
    n = 0;
    accu_x_host_model_i.send(op, ty, bank, 32'h0, bad);
    while (reply_valid_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    check("reply seen", 64'(n < 200), 64'h1);
    check("reply status", 64'(reply_o.status), 64'(st));
    @(posedge clk_i);
  endtask

  // Verdict and end of run
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    error_flags_t exp_flags;
    int n;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("reset state", 64'({accu_o | x_o, flags_o, irq_o, busy_o, param_valid_o, reply_valid_o}), 64'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      wb(1'b1, 4'h0, 32'hFFFFFFEF);
      wb(1'b1, 4'h1, 32'h5);
      cmd(`OP_ARITH, rows[i].ty, 8'h00, 1'b0, `ST_OK);
      check("accumulator", 64'(accu_o), 64'(rows[i].a));
      check("second operand", 64'(x_o), 64'(rows[i].x));
    end
    $display("arithmetic table done");
    // Damaged sum refused, accumulator kept
    cmd(`OP_ARITH, 8'h00, 8'h00, 1'b1, `ST_BAD_SUM);
    check("accumulator kept", 64'(accu_o), 64'h5);
    // Divide by zero and an unknown opcode refused
    wb(1'b1, 4'h1, 32'h0);
    cmd(`OP_ARITH, `TY_DIV, 8'h00, 1'b0, `ST_BAD_TYPE);
    cmd(8'h00, 8'h00, 8'h00, 1'b0, `ST_BAD_CMD);
    $display("refusal test done");
    // Accumulator loaded first, then both transfers
    @(posedge clk_i);
    accu_load_i <= 1'b1;
    accu_load_value_i <= 32'h12345678;
    @(posedge clk_i);
    accu_load_i <= 1'b0;
    cmd(`OP_AXIS_PARAM, 8'h07, 8'h00, 1'b0, `ST_OK);
    check("axis write", 64'(param_o), 64'({1'b1, 8'h07, 8'h00, 32'h12345678}));
    cmd(`OP_AXIS_PARAM, 8'h07, 8'h01, 1'b0, `ST_BAD_MOTOR);
    cmd(`OP_GLOBAL_PARAM, 8'h2A, 8'h02, 1'b0, `ST_OK);
    check("global write", 64'(param_o), 64'({1'b0, 8'h2A, 8'h02, 32'h12345678}));
    $display("transfer test done");
    // Flags cleared one by one, then all at once
    @(posedge clk_i);
    flag_set_i <= 5'h1F;
    @(posedge clk_i);
    flag_set_i <= 5'h00;
    exp_flags = 5'h1F;
    for (int t = 1; t <= 5; t++) begin
      cmd(`OP_CLEAR_FLAGS, 8'(t), 8'h00, 1'b0, `ST_OK);
      exp_flags[t] = 1'b0;
      check("flags", 64'(flags_o), 64'(exp_flags));
    end
    @(posedge clk_i);
    flag_set_i <= 5'h1F;
    @(posedge clk_i);
    flag_set_i <= 5'h00;
    cmd(`OP_CLEAR_FLAGS, 8'h00, 8'h00, 1'b0, `ST_OK);
    check("flags all", 64'(flags_o), 64'h0);
    $display("flag test done");
    // One source, then global processing
    cmd(`OP_INT_UNMASK, 8'h03, 8'h00, 1'b0, `ST_OK);
    check("source enable", 64'({int_global_enable_o, int_source_enable_o}), 64'h008);
    cmd(`OP_INT_UNMASK, `INT_GLOBAL, 8'h00, 1'b0, `ST_OK);
    check("global enable", 64'({int_global_enable_o, int_source_enable_o}), 64'h108);
    $display("unmask test done");
    // Status, mask, level interrupt and an unmapped read
    wb(1'b1, 4'h5, 32'h0);
    wb(1'b1, 4'h4, 32'hFFFFFFFF);
    @(posedge clk_i);
    flag_set_i <= 5'h02;
    @(posedge clk_i);
    flag_set_i <= 5'h00;
    wb(1'b0, 4'h2, 32'h0);
    check("flags read", 64'(rdat), 64'h4);
    check("irq masked", 64'(irq_o), 64'h0);
    wb(1'b1, 4'h5, 32'h4);
    repeat (2) @(posedge clk_i);
    check("irq raised", 64'(irq_o), 64'h1);
    wb(1'b1, 4'h4, 32'h4);
    repeat (2) @(posedge clk_i);
    check("irq cleared", 64'(irq_o), 64'h0);
    wb(1'b0, 4'hF, 32'h0);
    check("unmapped read", 64'(rdat), 64'h0);
    $display("interrupt test done");
    // Standalone command adds without a reply
    wb(1'b1, 4'h0, 32'h1);
    wb(1'b1, 4'h1, 32'h2);
    @(posedge clk_i);
    prog_valid_i <= 1'b1;
    prog_cmd_i <= '{`OP_ARITH, `TY_ADD, 8'h00, 32'h0};
    @(posedge clk_i);
    prog_valid_i <= 1'b0;
    n = 0;
    repeat (2) @(posedge clk_i);
    while (busy_o !== 1'b0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    check("program done", 64'(n < 100), 64'h1);
    check("program add", 64'(accu_o), 64'h3);
    $display("program test done");
    close_out();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    close_out();
  end
endmodule
